// ===== logic/tcd_pkg.sv
// Constants and types for the two-wire thermometer/clock command decoder.
// Assumes a 50 MHz system clock and a bus master that drives the serial clock.
// What this block does
// R01 - Stop-convert 22h lets the running conversion finish, then stays idle.
// R02 - Read temperature AAh returns last result, high byte first, then low byte.
// R03 - Master reads one temperature byte for whole degrees, two for finer.
// R04 - Read counter A8h returns one byte of residual count.
// R05 - Read slope A9h returns one byte of counts per degree.
// R06 - Access clock C0h writes clock registers on write, reads them on read.
// R07 - Access clock alarm C7h writes or reads the clock alarm registers.
// R08 - Master sends a start address after clock commands, then N bytes.
// R09 - Clock alarm flag clears only on clock or clock-alarm data access.
// R10 - Access A1h writes two bytes of upper threshold; read returns it.
// R11 - Access A2h writes two bytes of lower threshold; read returns it.
// R12 - Memory 17h takes an address, then bytes; pointer wraps 1Fh to 00h.
// R13 - Config ACh write takes exactly one byte; read gives config then status.
// R14 - Start-convert EEh starts conversions; one-shot needs one per reading.
// R15 - A nonvolatile write completes within the nonvolatile write time.
// R16 - Master waits the nonvolatile write time before another write.
// R17 - Control byte is type 1001, select bits 111, then direction bit.
// R18 - Device acknowledges its control byte; next byte is the command.
// R19 - Config first byte is writable, second is read-only status.
// R20 - Unknown command is refused and changes nothing until the next start.
// R21 - Every start or repeated start restarts decoding at the control byte.
package tcd_pkg;
  localparam logic [3:0]  DEV_TYPE      = 4'h9;
  localparam logic [2:0]  DEV_SEL       = 3'h7;
  localparam logic [7:0]  CMD_CONF      = 8'hAC;
  localparam logic [7:0]  CMD_MEM       = 8'h17;
  localparam logic [7:0]  CMD_CONV_GO   = 8'hEE;
  localparam logic [7:0]  CMD_CONV_STOP = 8'h22;
  localparam logic [7:0]  CMD_TEMP      = 8'hAA;
  localparam logic [7:0]  CMD_RESID     = 8'hA8;
  localparam logic [7:0]  CMD_SLOPE     = 8'hA9;
  localparam logic [7:0]  CMD_UPPER     = 8'hA1;
  localparam logic [7:0]  CMD_LOWER     = 8'hA2;
  localparam logic [7:0]  CMD_CLOCK     = 8'hC0;
  localparam logic [7:0]  CMD_CALARM    = 8'hC7;
  localparam logic [7:0]  IDLE_BYTE     = 8'hFF;
  localparam logic [4:0]  MEM_LAST      = 5'h1F;
  localparam logic [4:0]  CLK_MASK      = 5'h07;
  localparam logic [4:0]  CALM_MASK     = 5'h03;
  localparam logic [7:0]  CONF_RST      = 8'h00;
  localparam int          CONF_ONESHOT  = 0;
  // Wishbone register byte offsets
  localparam logic [3:0]  OFS_TEMP      = 4'h0;
  localparam logic [3:0]  OFS_RESID     = 4'h4;
  localparam logic [3:0]  OFS_STATUS    = 4'h8;
  localparam logic [3:0]  OFS_EVENT     = 4'hC;
  localparam int          ST_RUN_BIT    = 0;
  localparam int          ST_STOP_BIT   = 1;
  localparam int          ST_CAF_BIT    = 2;
  localparam int          ST_NV_BIT     = 3;
  // Nonvolatile write time
  localparam longint      CLK_HZ        = 50_000_000;
  localparam longint      NV_WRITE_MS   = 10;
  localparam int          NV_WRITE_CYC  = int'((NV_WRITE_MS * CLK_HZ) / 1000);

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} tcd_state_t;

  typedef struct packed {
    logic [7:0] slope;
    logic [7:0] remain;
  } tcd_resid_t;
endpackage

// ===== logic/tcd_decoder.sv
// Two-wire slave with command decoder for thermometer, thresholds, clock and memory.
// Assumes SCL and SDA arrive asynchronously; conversion results come over Wishbone.
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module tcd_decoder
  import tcd_pkg::*;
#(
  parameter int NV_CYC = NV_WRITE_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             conv_start_o,
  output logic             conv_run_o,
  output logic             clock_alarm_flag_o,
  output logic [15:0]      upper_temp_threshold_o,
  output logic [15:0]      lower_temp_threshold_o,
  output logic [7:0]       config_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  // ==========================================================================
  // Pin synchronisers and bus conditions
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end
  wire scl_rise  = scl_s2 & ~scl_s3;
  wire scl_fall  = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ==========================================================================
  // State
  tcd_state_t  state_reg;
  logic [7:0]  shift_reg, cmd_reg, config_reg;
  logic [3:0]  bit_cnt_reg;
  logic        ctrl_seen_reg, cmd_got_reg, cmd_ok_reg, rw_reg;
  logic [1:0]  idx_reg;
  logic [4:0]  ptr_reg;
  logic [15:0] upper_reg, lower_reg, temp_reg;
  tcd_resid_t  resid_reg;
  logic        caf_reg, run_reg, stop_pend_reg, start_reg, oe_n_reg;
  logic [31:0] nv_cnt_reg;
  logic        wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic [7:0]  mem [32];
  logic [7:0]  clk_regs [8];
  logic [7:0]  calm_regs [4];

  // ==========================================================================
  // Byte decode
  wire rx_done    = (state_reg == ST_RX) && (bit_cnt_reg == 4'h8) && scl_fall;
  wire ctrl_match = (shift_reg[7:1] == {DEV_TYPE, DEV_SEL});
  wire cmd_known  = (shift_reg == CMD_CONF)  || (shift_reg == CMD_MEM)
                 || (shift_reg == CMD_CONV_GO) || (shift_reg == CMD_CONV_STOP)
                 || (shift_reg == CMD_TEMP)  || (shift_reg == CMD_RESID)
                 || (shift_reg == CMD_SLOPE) || (shift_reg == CMD_UPPER)
                 || (shift_reg == CMD_LOWER) || (shift_reg == CMD_CLOCK)
                 || (shift_reg == CMD_CALARM);
  wire is_clkcmd  = (cmd_reg == CMD_CLOCK) || (cmd_reg == CMD_CALARM);
  wire is_addr    = is_clkcmd || (cmd_reg == CMD_MEM);
  wire is_thr     = (cmd_reg == CMD_UPPER) || (cmd_reg == CMD_LOWER);
  wire wr_ok      = cmd_ok_reg && (is_addr || (cmd_reg == CMD_CONF && idx_reg == 2'h0)
                 || (is_thr && idx_reg != 2'h2));                       // [R13] [R19]
  wire ctrl_byte  = rx_done && !ctrl_seen_reg;
  wire cmd_byte   = rx_done && ctrl_seen_reg && !cmd_got_reg;
  wire data_byte  = rx_done && ctrl_seen_reg && cmd_got_reg;
  wire byte_ack   = ctrl_byte ? ctrl_match : (cmd_byte ? cmd_known : wr_ok); // [R18] [R20]
  wire data_wr    = data_byte && wr_ok;
  wire addr_wr    = data_wr && is_addr && idx_reg == 2'h0;              // [R08]
  wire array_wr   = data_wr && is_addr && idx_reg != 2'h0;
  wire nv_wr      = data_wr && (is_thr || cmd_reg == CMD_CONF);
  wire tx_acked   = (state_reg == ST_TX_ACK) && scl_rise && !sda_s2;
  wire tx_nacked  = (state_reg == ST_TX_ACK) && scl_rise && sda_s2;
  wire go_cmd     = cmd_byte && shift_reg == CMD_CONV_GO;
  wire stop_cmd   = cmd_byte && shift_reg == CMD_CONV_STOP;
  wire caf_clr    = (array_wr || tx_acked) && is_clkcmd && cmd_ok_reg;  // [R09]
  wire [4:0] ptr_mask = (cmd_reg == CMD_CLOCK) ? CLK_MASK
                      : (cmd_reg == CMD_CALARM) ? CALM_MASK : MEM_LAST;
  wire [4:0] ptr_inc  = (ptr_reg + 5'h01) & ptr_mask;                   // [R12]
  wire [7:0] status_byte = {4'h0, nv_cnt_reg != 32'h0, caf_reg, stop_pend_reg, run_reg};

  logic [7:0] tx_byte;
  always_comb begin
    tx_byte = IDLE_BYTE;
    if (cmd_ok_reg) begin
      case (cmd_reg)
        CMD_TEMP:   tx_byte = idx_reg == 2'h0 ? temp_reg[15:8] : temp_reg[7:0];   // [R02]
        CMD_RESID:  tx_byte = resid_reg.remain;                                    // [R04]
        CMD_SLOPE:  tx_byte = resid_reg.slope;                                     // [R05]
        CMD_CONF:   tx_byte = idx_reg == 2'h0 ? config_reg : status_byte;          // [R13]
        CMD_UPPER:  tx_byte = idx_reg == 2'h0 ? upper_reg[15:8] : upper_reg[7:0];  // [R10]
        CMD_LOWER:  tx_byte = idx_reg == 2'h0 ? lower_reg[15:8] : lower_reg[7:0];  // [R11]
        CMD_MEM:    tx_byte = mem[ptr_reg];                                        // [R12]
        CMD_CLOCK:  tx_byte = clk_regs[ptr_reg[2:0]];                              // [R06]
        CMD_CALARM: tx_byte = calm_regs[ptr_reg[1:0]];                             // [R07]
        default:    tx_byte = IDLE_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // Serial byte engine
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      ctrl_seen_reg <= 1'b0;
      cmd_got_reg   <= 1'b0;
      oe_n_reg      <= 1'b1;
    end else if (start_det) begin                                       // [R21]
      state_reg     <= ST_RX;
      bit_cnt_reg   <= 4'h0;
      ctrl_seen_reg <= 1'b0;
      cmd_got_reg   <= 1'b0;
      oe_n_reg      <= 1'b1;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      oe_n_reg  <= 1'b1;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (rx_done) begin
            state_reg     <= byte_ack ? ST_RX_ACK : ST_IDLE;            // [R17] [R20]
            oe_n_reg      <= ~byte_ack;
            ctrl_seen_reg <= 1'b1;
            cmd_got_reg   <= ctrl_seen_reg;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall && rw_reg) begin
            state_reg   <= ST_TX;
            shift_reg   <= tx_byte;
            oe_n_reg    <= tx_byte[7];
            bit_cnt_reg <= 4'h1;
          end else if (scl_fall) begin
            state_reg   <= ST_RX;
            oe_n_reg    <= 1'b1;
            bit_cnt_reg <= 4'h0;
          end
        end
        ST_TX: begin
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            state_reg <= ST_TX_ACK;
            oe_n_reg  <= 1'b1;
          end else if (scl_fall) begin
            shift_reg   <= {shift_reg[6:0], 1'b0};
            oe_n_reg    <= shift_reg[6];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        ST_TX_ACK: begin
          if (tx_nacked) begin
            state_reg <= ST_IDLE;
          end else if (scl_fall) begin
            state_reg   <= ST_TX;
            shift_reg   <= tx_byte;
            oe_n_reg    <= tx_byte[7];
            bit_cnt_reg <= 4'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Command context and stored registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rw_reg     <= 1'b0;
      cmd_reg    <= 8'h00;
      cmd_ok_reg <= 1'b0;
      idx_reg    <= 2'h0;
      ptr_reg    <= 5'h00;
      config_reg <= CONF_RST;
      upper_reg  <= 16'h0000;
      lower_reg  <= 16'h0000;
    end else begin
      if (start_det) idx_reg <= 2'h0;
      if (ctrl_byte && ctrl_match) rw_reg <= shift_reg[0];
      if (cmd_byte) begin
        cmd_reg    <= shift_reg;
        cmd_ok_reg <= cmd_known;
      end
      if ((data_wr || tx_acked) && idx_reg != 2'h2) idx_reg <= idx_reg + 2'h1;
      if (addr_wr) ptr_reg <= shift_reg[4:0] & ptr_mask;                // [R08]
      else if (array_wr || (tx_acked && is_addr)) ptr_reg <= ptr_inc;   // [R12]
      if (data_wr && cmd_reg == CMD_CONF) config_reg <= shift_reg;      // [R13]
      if (data_wr && cmd_reg == CMD_UPPER) begin                        // [R10]
        if (idx_reg == 2'h0) upper_reg[15:8] <= shift_reg;
        else upper_reg[7:0] <= shift_reg;
      end
      if (data_wr && cmd_reg == CMD_LOWER) begin                        // [R11]
        if (idx_reg == 2'h0) lower_reg[15:8] <= shift_reg;
        else lower_reg[7:0] <= shift_reg;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (array_wr && cmd_reg == CMD_MEM) mem[ptr_reg] <= shift_reg;               // [R12]
    if (array_wr && cmd_reg == CMD_CLOCK) clk_regs[ptr_reg[2:0]] <= shift_reg;   // [R06]
    if (array_wr && cmd_reg == CMD_CALARM) calm_regs[ptr_reg[1:0]] <= shift_reg; // [R07]
  end

  // ==========================================================================
  // Conversion control, alarm flag and nonvolatile write timer
  wire wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  wire wb_wr      = wb_req & wb_we_i;
  wire result_in  = wb_wr && wb_adr_i == OFS_TEMP;
  wire caf_set    = wb_wr && wb_adr_i == OFS_EVENT && wb_sel_i[0] && wb_dat_i[0];
  wire run_end    = result_in && (config_reg[CONF_ONESHOT] || stop_pend_reg);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_reg       <= 1'b0;
      stop_pend_reg <= 1'b0;
      start_reg     <= 1'b0;
      caf_reg       <= 1'b0;
      nv_cnt_reg    <= 32'h0;
    end else begin
      start_reg <= go_cmd;                                              // [R14]
      if (go_cmd) begin
        run_reg       <= 1'b1;
        stop_pend_reg <= 1'b0;
      end else if (stop_cmd && run_reg) begin
        stop_pend_reg <= 1'b1;                                          // [R01]
      end else if (run_end) begin
        run_reg       <= 1'b0;                                          // [R01] [R14]
        stop_pend_reg <= 1'b0;
      end
      caf_reg <= caf_set | (caf_reg & ~caf_clr);                        // [R09]
      if (nv_wr) nv_cnt_reg <= 32'(NV_CYC);                             // [R15]
      else if (nv_cnt_reg != 32'h0) nv_cnt_reg <= nv_cnt_reg - 32'h1;
    end
  end

  // ==========================================================================
  // Wishbone slave, answers one cycle after the request
  wire [31:0] wb_rd = (wb_adr_i == OFS_TEMP)   ? {16'h0000, temp_reg}
                    : (wb_adr_i == OFS_RESID)  ? {16'h0000, resid_reg}
                    : (wb_adr_i == OFS_STATUS) ? {24'h000000, status_byte}
                    : 32'h00000000;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
      temp_reg   <= 16'h0000;
      resid_reg  <= '0;
    end else begin
      wb_ack_reg <= wb_req;
      wb_dat_reg <= wb_req ? wb_rd : 32'h0;
      if (result_in && wb_sel_i[0]) temp_reg[7:0] <= wb_dat_i[7:0];
      if (result_in && wb_sel_i[1]) temp_reg[15:8] <= wb_dat_i[15:8];
      if (wb_wr && wb_adr_i == OFS_RESID && wb_sel_i[0]) resid_reg.remain <= wb_dat_i[7:0];
      if (wb_wr && wb_adr_i == OFS_RESID && wb_sel_i[1]) resid_reg.slope <= wb_dat_i[15:8];
    end
  end

  assign sda_o                  = 1'b0;
  assign sda_oe_n_o             = oe_n_reg;
  assign conv_start_o           = start_reg;
  assign conv_run_o             = run_reg;
  assign clock_alarm_flag_o     = caf_reg;
  assign upper_temp_threshold_o = upper_reg;
  assign lower_temp_threshold_o = lower_reg;
  assign config_o               = config_reg;
  assign wb_dat_o               = wb_dat_reg;
  assign wb_ack_o               = wb_ack_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_byte_refused;
    state_reg == ST_IDLE && oe_n_reg;
  endsequence

  ctrl_ack_a: assert property (ctrl_byte && ctrl_match && !start_det && !stop_det |=> // [R18]
    state_reg == ST_RX_ACK && !sda_oe_n_o) else $error("control byte not acknowledged");
  ctrl_refuse_a: assert property (ctrl_byte && !ctrl_match && !start_det && !stop_det // [R17]
    |=> s_byte_refused) else $error("foreign control byte acknowledged");
  restart_dec_a: assert property (start_det |=> state_reg == ST_RX && !ctrl_seen_reg // [R21]
    && bit_cnt_reg == 4'h0) else $error("start did not restart decoding");
  bad_cmd_a: assert property (cmd_byte && !cmd_known && !start_det && !stop_det // [R20]
    |=> s_byte_refused ##1 $stable(config_reg) && $stable(run_reg))
    else $error("unknown command not refused");
  conv_go_a: assert property (go_cmd |=> conv_start_o && conv_run_o ##1 !conv_start_o) // [R14]
    else $error("start convert not taken");
  conv_stop_a: assert property (stop_cmd && run_reg && !result_in |=> conv_run_o // [R01]
    && stop_pend_reg) else $error("stop did not wait for conversion");
  caf_clear_a: assert property (caf_clr && !caf_set |=> !clock_alarm_flag_o) // [R09]
    else $error("clock alarm flag not cleared");
  mem_wrap_a: assert property (array_wr && cmd_reg == CMD_MEM && ptr_reg == MEM_LAST // [R12]
    |=> ptr_reg == 5'h00) else $error("memory pointer did not wrap");
  conf_one_a: assert property (data_byte && cmd_reg == CMD_CONF && idx_reg != 2'h0 // [R13]
    && !start_det && !stop_det |=> s_byte_refused) else $error("second config byte taken");
  nv_time_a: assert property (nv_wr |=> nv_cnt_reg == 32'(NV_CYC) ##1 // [R15]
    nv_cnt_reg == 32'(NV_CYC) - 32'h1 || nv_wr) else $error("nonvolatile timer wrong");
endmodule // tcd_decoder
`default_nettype wire

// ===== verif/tcd_master.sv
// Two-wire bus master model: makes the serial clock and drives data.
// Assumes the bench resolves the pulled-up data wire into sda_i.
`timescale 1ns/1ps
`default_nettype none
module tcd_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ==========================================================
  // Conditions; the clock stands high between frames
  task automatic start();
    tick(2);
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= 1'b1;
    tick(2);
  endtask
  // One bit of 160 ns; data sampled mid-high
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
    scl_o <= 1'b0;
  endtask
  // Byte plus acknowledge bit; ackin 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic ackin, output logic [7:0] q,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ackin, a);
    ack = ~a;
  endtask
endmodule // tcd_master
`default_nettype wire

// ===== verif/test_thermo_clock_command_decoder.sv
// Self-checking bench of the command decoder with a serial master model.
// Assumes the package and decoder are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_thermo_clock_command_decoder import tcd_pkg::*;;
  localparam int NV = 200;
  logic        mclk_i = 1'b0, arst_n_i = 1'b0, scl, mst_sda, sda_o, sda_oe_n_o;
  logic        conv_start_o, conv_run_o, caf, wb_ack_o;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] upper, lower;
  logic [7:0]  config_o;
  int          miscompares, compares, starts, s0, n;
  wire logic   sda = mst_sda & (sda_oe_n_o | sda_o);
  tcd_decoder #(.NV_CYC(NV)) u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .conv_start_o(conv_start_o),
    .conv_run_o(conv_run_o), .clock_alarm_flag_o(caf), .upper_temp_threshold_o(upper),
    .lower_temp_threshold_o(lower), .config_o(config_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  tcd_master u_mst (.clk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_o(mst_sda));
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (conv_start_o === 1'b1) starts <= starts + 1;
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic sb(input logic [7:0] d, input logic ack);
    logic [7:0] q;
    logic       a;
    u_mst.xfer(d, 1'b1, q, a);
    check(a, ack);
  endtask
  task automatic cmdw(input logic [7:0] c);
    u_mst.start();
    sb(8'h9E, 1'b1);
    sb(c, 1'b1);
  endtask
  // Repeated start, read n bytes high first, master refuses the last
  task automatic rdn(input logic [15:0] e, input int cnt);
    logic [7:0] q;
    logic       a;
    u_mst.start();
    sb(8'h9F, 1'b1);
    for (int k = 0; k < cnt; k++) begin
      u_mst.xfer(8'hFF, k == cnt - 1, q, a);
      check(q, e[15 - 8 * k -: 8]);
    end
    u_mst.stop();
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_config();
    check({sda_oe_n_o, conv_run_o, caf, config_o, upper, lower}, 43'h400_0000_0000);
    cmdw(CMD_CONF);
    sb(8'h10, 1'b1);
    sb(8'h77, 1'b0);
    u_mst.stop();
    check(config_o, 8'h10);
    repeat (NV) @(posedge mclk_i);
    u_mst.start();
    sb(8'h90, 1'b0);
    u_mst.stop();
    u_mst.start();
    sb(8'h9E, 1'b1);
    sb(8'h55, 1'b0);
    u_mst.stop();
    check(config_o, 8'h10);
    cmdw(CMD_CONF);
    rdn(16'h1000, 1);
  endtask
  task automatic t_thresh();
    logic [7:0] c;
    for (int i = 0; i < 2; i++) begin
      c = (i == 1) ? CMD_LOWER : CMD_UPPER;
      cmdw(c);
      sb(8'(8'h32 + i), 1'b1);
      sb(8'h80, 1'b1);
      sb(8'h01, 1'b0);
      u_mst.stop();
      wb(1'b0, OFS_STATUS, 32'h0);
      check(rd[ST_NV_BIT], 1'b1);
      n = 0;
      while (rd[ST_NV_BIT] !== 1'b0 && n < NV) begin
        wb(1'b0, OFS_STATUS, 32'h0);
        n++;
      end
      check(rd[ST_NV_BIT], 1'b0);
      cmdw(c);
      rdn(16'(16'h3280 + 16'h0100 * i), 2);
    end
    check({upper, lower}, 32'h3280_3380);
  endtask
  task automatic t_temp();
    wb(1'b1, OFS_TEMP, 32'h0000_C3A5);
    wb(1'b1, OFS_RESID, 32'h0000_5A3C);
    cmdw(CMD_TEMP);
    rdn(16'hC3A5, 2);
    cmdw(CMD_TEMP);
    rdn(16'hC300, 1);
    cmdw(CMD_RESID);
    rdn(16'h3C00, 1);
    cmdw(CMD_SLOPE);
    rdn(16'h5A00, 1);
  endtask
  task automatic t_conv();
    s0 = starts;
    cmdw(CMD_CONV_GO);
    sb(8'h00, 1'b0);
    u_mst.stop();
    check({starts - s0, conv_run_o}, 33'h3);
    cmdw(CMD_CONV_STOP);
    sb(8'h00, 1'b0);
    u_mst.stop();
    check(conv_run_o, 1'b1);
    wb(1'b1, OFS_TEMP, 32'h0000_1900);
    wb(1'b0, OFS_STATUS, 32'h0);
    check({rd[ST_RUN_BIT], conv_run_o}, 2'b00);
    cmdw(CMD_CONV_GO);
    u_mst.stop();
    check({starts - s0, conv_run_o}, 33'h5);
    // Continuous mode keeps running after a result; one-shot stops after the next one
    wb(1'b1, OFS_TEMP, 32'h0000_1A00);
    check(conv_run_o, 1'b1);
    cmdw(CMD_CONF);
    sb(8'h11, 1'b1);
    u_mst.stop();
    repeat (NV) @(posedge mclk_i);
    wb(1'b1, OFS_TEMP, 32'h0000_1B00);
    check({conv_run_o, config_o}, 9'h011);
  endtask
  task automatic t_mem();
    wb(1'b1, OFS_EVENT, 32'h1);
    cmdw(CMD_MEM);
    sb({3'h0, MEM_LAST}, 1'b1);
    sb(8'hA0, 1'b1);
    sb(8'hA1, 1'b1);
    u_mst.stop();
    cmdw(CMD_MEM);
    sb(8'h00, 1'b1);
    rdn(16'hA1A1, 1);
    cmdw(CMD_MEM);
    sb({3'h0, MEM_LAST}, 1'b1);
    rdn(16'hA0A1, 2);
    check(caf, 1'b1);
  endtask
  task automatic t_clock();
    for (int i = 0; i < 2; i++) begin
      cmdw(i == 1 ? CMD_CALARM : CMD_CLOCK);
      sb({3'h0, i == 1 ? CALM_MASK : CLK_MASK}, 1'b1);
      sb(8'h11, 1'b1);
      sb(8'h22, 1'b1);
      u_mst.stop();
      check(caf, 1'b0);
      wb(1'b1, OFS_EVENT, 32'h1);
      check(caf, 1'b1);
      cmdw(i == 1 ? CMD_CALARM : CMD_CLOCK);
      sb({3'h0, i == 1 ? CALM_MASK : CLK_MASK}, 1'b1);
      rdn(16'h1122, 2);
      check(caf, 1'b0);
      wb(1'b1, OFS_EVENT, 32'h1);
    end
  endtask
  initial begin
    #(1_000_000);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_config();
    t_thresh();
    t_temp();
    t_conv();
    t_mem();
    t_clock();
    end_of_test();
  end
endmodule // test_thermo_clock_command_decoder
`default_nettype wire
